// ===== rtl/faa_flash_array_access.sv
// Purpose: Fetch path and program/erase sequencer of an embedded flash.
// Assumes: CPU clock is the block clock; system clock runs four times faster.
// Notes: The array is modelled by a small ECC-protected byte memory.
// Summary of operation
// - Program covers 64-byte code, 32-byte data row.
// - Erase unit is one whole sector.
// - Several sectors erase together or singly.
// - Erased cells read as zero.
// - Program lasts 248256 system clocks.
// - Program and erase run in background.
// - Erase in progress can be aborted.
// - ECC corrects single-bit errors on read.
// - Parallel fetch reads two bytes in three cycles.
// - Byte pair takes four parallel, six serial.
// - Cache hit completes in one cycle.
// - Parallel read can be switched off.
// - Code sectors pair with partner bank sector.
// - Large part has six code, two data banks.
// - Small part: six code banks, one data.
`timescale 1ns/1ns
`include "faa_map.svh"
module faa_flash_array_access
  import faa_pkg::*;
#(
  parameter int SYS_PER_CPU_CLOCK_CYCLE = 4,
  parameter int PROG_CYCLES = `FAA_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FAA_ERASE_CYCLES,
  parameter bit BIG_CONFIG = 1'b1,
  parameter int DEPTH = 256
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Fetch port.
  input wire faa_fetch_t fetch_in,
  input wire logic parallel_en_in,
  output logic [7:0] fetch_data_out,
  output logic fetch_ready_out,
  // Operation port.
  input wire faa_op_t op_in,
  input wire logic [7:0] wr_data_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic [5:0] wr_index_out,
  output logic [3:0] code_banks_out,
  output logic [1:0] data_banks_out
);
  // ****************************************
  // Constants
  // ****************************************
  // Counts in CPU cycles, rounded up from system clocks.
  localparam int PROG_CPU_CLOCK_CYCLE = (PROG_CYCLES + SYS_PER_CPU_CLOCK_CYCLE - 1) / SYS_PER_CPU_CLOCK_CYCLE;
  localparam int ERASE_CPU_CLOCK_CYCLE = (ERASE_CYCLES + SYS_PER_CPU_CLOCK_CYCLE - 1) / SYS_PER_CPU_CLOCK_CYCLE;
  localparam int AW = $clog2(DEPTH);

  // Hamming(12,8) encode: parity bits at positions 1,2,4,8.
  function automatic logic [11:0] ecc_enc(input logic [7:0] d);
    logic [11:0] c;
    c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
    c[0] = c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
    c[1] = c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
    c[3] = c[4] ^ c[5] ^ c[6] ^ c[11];
    c[7] = c[8] ^ c[9] ^ c[10] ^ c[11];
    return c;
  endfunction

  // Decode with single-bit correction by syndrome.
  function automatic logic [7:0] ecc_dec(input logic [11:0] c);
    logic [3:0] s;
    logic [11:0] f;
    s[0] = c[0] ^ c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
    s[1] = c[1] ^ c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
    s[2] = c[3] ^ c[4] ^ c[5] ^ c[6] ^ c[11];
    s[3] = c[7] ^ c[8] ^ c[9] ^ c[10] ^ c[11];
    f = c;
    if (s != 4'h0 && s <= 4'hc) begin
      f[s - 4'h1] = ~c[s - 4'h1];
    end
    return {f[11:8], f[6:4], f[2]};
  endfunction

  // ****************************************
  // Array storage
  // ****************************************
  // Each code word pairs a byte of one bank with the partner bank byte.
  logic [11:0] mem_lo [DEPTH];
  logic [11:0] mem_hi [DEPTH];

  // ****************************************
  // Fetch path
  // ****************************************
  typedef enum logic [2:0] {
    FAA_F_IDLE = 3'b001,
    FAA_F_ACC = 3'b010,
    FAA_F_DONE = 3'b100
  } faa_fstate_t;
  faa_fstate_t fst_q, fst_d;
  logic [1:0] fcnt_q, fcnt_d;
  logic [13:0] tag_q, tag_d;
  logic tag_ok_q, tag_ok_d;
  logic [15:0] cache_q, cache_d;
  logic [14:0] faddr_q, faddr_d;
  logic [7:0] fdata_q, fdata_d;
  logic frdy_q, frdy_d;
  logic hit;
  // Array write and erase strobes, driven by the sequencer below.
  logic op_wr, erase_now;
  // The cache holds the byte pair of one even address.
  assign hit = tag_ok_q && parallel_en_in && tag_q == fetch_in.addr[14:1];
  // Next-state for the fetch path.
  always_comb begin
    fst_d = fst_q;
    fcnt_d = fcnt_q;
    tag_d = tag_q;
    tag_ok_d = tag_ok_q;
    cache_d = cache_q;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    frdy_d = 1'b0;
    unique case (fst_q)
      FAA_F_IDLE: begin
        if (fetch_in.valid && hit) begin
          fdata_d = fetch_in.addr[0] ? cache_q[15:8] : cache_q[7:0];
          frdy_d = 1'b1;
          fst_d = FAA_F_DONE;
        end else if (fetch_in.valid) begin
          faddr_d = fetch_in.addr;
          fcnt_d = 2'h0;
          fst_d = FAA_F_ACC;
        end
      end
      FAA_F_ACC: begin
        fcnt_d = fcnt_q + 2'h1;
        if (fcnt_q == 2'(`FAA_ARRAY_CPU_CLOCK_CYCLE - 1)) begin
          cache_d = {ecc_dec(mem_hi[faddr_q[AW:1]]), ecc_dec(mem_lo[faddr_q[AW:1]])};
          fdata_d = faddr_q[0] ? cache_d[15:8] : cache_d[7:0];
          tag_d = faddr_q[14:1];
          tag_ok_d = parallel_en_in;
          frdy_d = 1'b1;
          fst_d = FAA_F_DONE;
        end
      end
      FAA_F_DONE: begin
        // One idle cycle lets the requester drop or change valid.
        fst_d = FAA_F_IDLE;
      end
      default: fst_d = FAA_F_IDLE;
    endcase
    // Program writes and finished erases make the cached pair stale.
    if (op_wr || erase_now) begin
      tag_ok_d = 1'b0;
    end
  end
  // ****************************************
  // Program / erase sequencer
  // ****************************************
  typedef enum logic [2:0] {
    FAA_S_IDLE = 3'b001,
    FAA_S_LOAD = 3'b010,
    FAA_S_WAIT = 3'b100
  } faa_sstate_t;
  faa_sstate_t sst_q, sst_d;
  logic [23:0] tcnt_q, tcnt_d;
  logic [5:0] widx_q, widx_d;
  logic [5:0] wlen_q, wlen_d;
  faa_op_t op_q, op_d;
  logic busy_q, busy_d;
  logic [AW:0] wr_ptr;
  // Writes from the load buffer go straight to the array model.
  assign op_wr = sst_q == FAA_S_LOAD;
  assign erase_now = sst_q == FAA_S_WAIT && tcnt_q == 24'h0 &&
    op_q.cmd == FAA_CMD_ERASE && !abort_in;
  assign wr_ptr = (AW+1)'({op_q.row, 5'h00} + {9'h000, widx_q});

  // Next-state for the sequencer.
  always_comb begin
    sst_d = sst_q;
    tcnt_d = tcnt_q;
    widx_d = widx_q;
    wlen_d = wlen_q;
    op_d = op_q;
    busy_d = busy_q;
    unique case (sst_q)
      FAA_S_IDLE: begin
        if (op_in.cmd == FAA_CMD_PROG) begin
          op_d = op_in;
          wlen_d = op_in.data_bank ? 6'(`FAA_DATA_ROW_BYTES - 1) : 6'(`FAA_CODE_ROW_BYTES - 1);
          widx_d = 6'h00;
          busy_d = 1'b1;
          sst_d = FAA_S_LOAD;
        end else if (op_in.cmd == FAA_CMD_ERASE && op_in.sector_mask != 8'h00) begin
          op_d = op_in;
          tcnt_d = 24'(ERASE_CPU_CLOCK_CYCLE - 1);
          busy_d = 1'b1;
          sst_d = FAA_S_WAIT;
        end
      end
      FAA_S_LOAD: begin
        widx_d = (widx_q == wlen_q) ? widx_q : widx_q + 6'h01;
        if (widx_q == wlen_q) begin
          tcnt_d = 24'(PROG_CPU_CLOCK_CYCLE - 1);
          sst_d = FAA_S_WAIT;
        end
      end
      FAA_S_WAIT: begin
        tcnt_d = tcnt_q - 24'h1;
        if (abort_in && op_q.cmd == FAA_CMD_ERASE) begin
          busy_d = 1'b0;
          sst_d = FAA_S_IDLE;
        end else if (tcnt_q == 24'h0) begin
          busy_d = 1'b0;
          sst_d = FAA_S_IDLE;
        end
      end
      default: sst_d = FAA_S_IDLE;
    endcase
  end

  // One process owns the array: program ORs ones in, erase clears whole sectors.
  always_ff @(posedge clock_in) begin
    if (erase_now) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (op_q.sector_mask[i / (DEPTH / `FAA_SECTORS)]) begin
          mem_lo[i] <= ecc_enc(`FAA_ERASED_BYTE);
          mem_hi[i] <= ecc_enc(`FAA_ERASED_BYTE);
        end
      end
    end else if (op_wr) begin
      if (wr_ptr[0]) begin
        mem_hi[wr_ptr[AW:1]] <= ecc_enc(ecc_dec(mem_hi[wr_ptr[AW:1]]) | wr_data_in);
      end else begin
        mem_lo[wr_ptr[AW:1]] <= ecc_enc(ecc_dec(mem_lo[wr_ptr[AW:1]]) | wr_data_in);
      end
    end
  end

  // Registers for both state groups.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fst_q <= FAA_F_IDLE;
      fcnt_q <= 2'h0;
      tag_q <= 14'h0000;
      tag_ok_q <= 1'b0;
      cache_q <= 16'h0000;
      faddr_q <= 15'h0000;
      fdata_q <= 8'h00;
      frdy_q <= 1'b0;
      sst_q <= FAA_S_IDLE;
      tcnt_q <= 24'h000000;
      widx_q <= 6'h00;
      wlen_q <= 6'h00;
      op_q <= '0;
      busy_q <= 1'b0;
    end else begin
      fst_q <= fst_d;
      fcnt_q <= fcnt_d;
      tag_q <= tag_d;
      tag_ok_q <= tag_ok_d;
      cache_q <= cache_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
      frdy_q <= frdy_d;
      sst_q <= sst_d;
      tcnt_q <= tcnt_d;
      widx_q <= widx_d;
      wlen_q <= wlen_d;
      op_q <= op_d;
      busy_q <= busy_d;
    end
  end

  // Outputs straight from flip-flops.
  assign fetch_data_out = fdata_q;
  assign fetch_ready_out = frdy_q;
  assign busy_out = busy_q;
  assign wr_index_out = widx_q;
  // small part has one data bank
  assign code_banks_out = 4'(`FAA_CODE_BANKS_BIG);
  assign data_banks_out = BIG_CONFIG ? 2'(`FAA_DATA_BANKS_BIG) : 2'(`FAA_DATA_BANKS_SMALL);
  // ****************************************
  // Checks
  // ****************************************
  a_busy_prog: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sst_q == FAA_S_IDLE && op_in.cmd == FAA_CMD_PROG |=> busy_q)
    else $error("busy not raised on program");
  a_abort_erase: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sst_q == FAA_S_WAIT && abort_in && op_q.cmd == FAA_CMD_ERASE |=> !busy_q)
    else $error("erase abort ignored");
  a_miss_latency: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    fst_q == FAA_F_IDLE && fetch_in.valid && !hit |=> !frdy_q [*3] ##1 frdy_q)
    else $error("miss latency wrong");
  a_hit_latency: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    fst_q == FAA_F_IDLE && fetch_in.valid && hit |=> frdy_q)
    else $error("hit not one cycle");
  a_serial_nocache: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !parallel_en_in && fst_q == FAA_F_IDLE && fetch_in.valid |=> fst_q == FAA_F_ACC)
    else $error("cache used in serial mode");
  a_load_len: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sst_q == FAA_S_LOAD && $past(sst_q) == FAA_S_IDLE && op_q.data_bank
    |-> (sst_q == FAA_S_LOAD) [*8])
    else $error("data row load too short");
  a_erase_mask: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sst_q == FAA_S_IDLE && op_in.cmd == FAA_CMD_ERASE && op_in.sector_mask == 8'h00
    |=> sst_q == FAA_S_IDLE)
    else $error("empty erase started");
  a_busy_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sst_q == FAA_S_WAIT && tcnt_q > 24'h1 && !abort_in |=> busy_q)
    else $error("busy dropped early");
  a_fetch_bg: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    busy_q && fst_q == FAA_F_ACC && fcnt_q == 2'h2 |=> frdy_q)
    else $error("fetch stalled by operation");
  a_ecc_single: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    frdy_q |-> ecc_dec(ecc_enc(fdata_q) ^ (12'h001 << faddr_q[3:0])) == fdata_q)
    else $error("single-bit error not corrected");
  c_hit: cover property (@(posedge clock_in) fetch_in.valid && hit);
  c_prog: cover property (@(posedge clock_in) sst_q == FAA_S_LOAD);
  c_abort: cover property (@(posedge clock_in) sst_q == FAA_S_WAIT && abort_in);
endmodule

// ===== rtl/faa_map.svh
// Purpose: Constants for the flash array access block.
// Assumes: Included by the design file only.
// Notes: Program and erase counts are in system clock periods; fetch and pair counts are in CPU cycles.
`ifndef FAA_MAP_SVH
`define FAA_MAP_SVH
// ****************************************
// Geometry
// ****************************************
`define FAA_CODE_ROW_BYTES 64
`define FAA_DATA_ROW_BYTES 32
`define FAA_CODE_BANKS_BIG 6
`define FAA_DATA_BANKS_BIG 2
`define FAA_DATA_BANKS_SMALL 1
`define FAA_SMALL_UPPER_KBYTES 2
`define FAA_SECTORS 8
// ****************************************
// Timing
// ****************************************
`define FAA_PROG_CYCLES 248256
`define FAA_ERASE_CYCLES 9807360
`define FAA_ARRAY_CPU_CLOCK_CYCLE 3
`define FAA_PAR_PAIR_CPU_CLOCK_CYCLE 4
`define FAA_SER_PAIR_CPU_CLOCK_CYCLE 6
`define FAA_ERASED_BYTE 8'h00
`endif

// ===== rtl/faa_pkg.sv
// Purpose: Types shared by the flash array access block.
// Assumes: Constants come from faa_map.svh.
// Notes: Holds types only.
package faa_pkg;
  // Operation commands.
  typedef enum logic [1:0] {
    FAA_CMD_NONE = 2'h0,
    FAA_CMD_PROG = 2'h1,
    FAA_CMD_ERASE = 2'h2
  } faa_cmd_t;
  // Fetch request from the CPU.
  typedef struct packed {
    logic valid;
    logic [14:0] addr;
  } faa_fetch_t;
  // Array operation request.
  typedef struct packed {
    faa_cmd_t cmd;
    logic data_bank;
    logic [7:0] sector_mask;
    logic [9:0] row;
  } faa_op_t;
endpackage

// ===== tb/faa_cpu_model.sv
// Purpose: CPU fetch side model for the flash block.
// Assumes: Level request held until ready is sampled high.
// Notes: Address is inverted once the request is released.
`timescale 1ns/1ns
module faa_cpu_model
  import faa_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Bench side.
  input wire logic req_in,
  input wire logic [14:0] addr_in,
  output logic done_out,
  output logic [7:0] data_out,
  output logic [3:0] lat_out,
  // Flash side.
  input wire logic fetch_ready_in,
  input wire logic [7:0] fetch_data_in,
  output faa_fetch_t fetch_out
);
  // Edges counted while the request waits.
  logic [3:0] cnt_q;
  // ****
  // Request and answer
  // ****
  // The request never drops before ready, so no fetch is lost.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fetch_out <= '0;
      cnt_q <= 4'h0;
      done_out <= 1'b0;
      data_out <= 8'h00;
      lat_out <= 4'h0;
    end else begin
      done_out <= 1'b0;
      if (!fetch_out.valid && req_in) begin
        fetch_out <= {1'b1, addr_in};
        cnt_q <= 4'h0;
      end else if (fetch_out.valid && fetch_ready_in) begin
        // Released lines must not keep the old address.
        fetch_out <= {1'b0, ~fetch_out.addr};
        data_out <= fetch_data_in;
        lat_out <= cnt_q;
        done_out <= 1'b1;
      end else if (fetch_out.valid) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// ===== tb/test_flash_array_access.sv
// Purpose: Self-checking bench of the flash array access block.
// Assumes: Short program and erase counts of 40 and 80.
// Notes: Latencies are compared as differences between fetches.
`timescale 1ns/1ns
module test_flash_array_access;
  import faa_pkg::*;
  // Clock, reset and stimulus.
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic par_en = 1'b1;
  logic abort = 1'b0;
  logic req = 1'b0;
  logic [14:0] addr = 15'h0000;
  faa_op_t op = '0;
  // Program data mode: 0 all bytes, 1 lower half only, 2 upper half only.
  logic [1:0] wmode = 2'h0;
  // Design outputs and model outputs.
  faa_fetch_t fetch;
  logic [7:0] fdata, wdata, mdata;
  logic [5:0] widx;
  logic [3:0] cbanks, lat, lat_m;
  logic [1:0] dbanks;
  logic frdy, busy, done;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // Program bytes follow the load index; a split pass writes zeros elsewhere.
  assign wdata = (wmode == 2'h0 || widx[4] == wmode[1]) ? ({2'h0, widx} ^ 8'ha5) : 8'h00;
  faa_flash_array_access #(.PROG_CYCLES(40), .ERASE_CYCLES(80)) u_faa_flash_array_access (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .fetch_in(fetch),
    .parallel_en_in(par_en), .fetch_data_out(fdata), .fetch_ready_out(frdy),
    .op_in(op), .wr_data_in(wdata), .abort_in(abort), .busy_out(busy),
    .wr_index_out(widx), .code_banks_out(cbanks), .data_banks_out(dbanks));
  faa_cpu_model u_faa_cpu_model (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .req_in(req), .addr_in(addr),
    .done_out(done), .data_out(mdata), .lat_out(lat), .fetch_ready_in(frdy),
    .fetch_data_in(fdata), .fetch_out(fetch));
  // ****
  // Clock, watchdog, shared tasks
  // ****
  initial begin
    forever #20 clock_in = ~clock_in;
  end
  // A hang is cut short well past the longest expected run.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fetch_byte(input logic [14:0] a, output logic [7:0] d, output logic [3:0] l);
    int n;
    @(posedge clock_in);
    req <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    req <= 1'b0;
    addr <= ~a;
    for (n = 0; n < 50 && done !== 1'b1; n++) @(posedge clock_in);
    d = mdata;
    l = lat;
  endtask
  // Issues one operation and counts the cycles with busy high.
  task automatic run_op(input faa_op_t o, input int abort_at, output int cnt, output int mx);
    int n;
    cnt = 0;
    mx = 0;
    @(posedge clock_in);
    op <= o;
    @(posedge clock_in);
    op <= '0;
    for (n = 0; n < 300; n++) begin
      @(posedge clock_in);
      if (cnt == abort_at) abort <= 1'b1;
      if (busy === 1'b1) begin
        cnt++;
        if (widx > mx) mx = widx;
      end else if (cnt > 0) break;
    end
    abort <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_erase_all();
    int c, m;
    logic [7:0] d;
    logic [3:0] l;
    run_op('{FAA_CMD_ERASE, 1'b0, 8'hff, 10'h000}, -1, c, m);
    check(16'(c), 16'd20);
    fetch_byte(15'h0020, d, l);
    check({8'h00, d}, 16'h0000);
  endtask
  task automatic t_prog_fetch();
    int c, m;
    logic [7:0] d;
    logic [3:0] l0, l1;
    // Row erased above, so a single program pass is allowed.
    run_op('{FAA_CMD_PROG, 1'b0, 8'h00, 10'h000}, -1, c, m);
    check(16'(m), 16'd63);
    check(16'(c), 16'd74);
    fetch_byte(15'h0010, d, l0);
    check({8'h00, d}, 16'h00b5);
    fetch_byte(15'h0011, d, l1);
    check({8'h00, d}, 16'h00b4);
    check({12'h000, l0 - l1}, 16'h0003);
    lat_m = l0;
    par_en <= 1'b0;
    fetch_byte(15'h0011, d, l1);
    check({12'h000, l1}, {12'h000, lat_m});
    check({8'h00, d}, 16'h00b4);
    par_en <= 1'b1;
  endtask
  task automatic t_background();
    int n;
    logic [7:0] d;
    logic [3:0] l;
    @(posedge clock_in);
    op <= '{FAA_CMD_ERASE, 1'b0, 8'h80, 10'h000};
    @(posedge clock_in);
    op <= '0;
    fetch_byte(15'h0010, d, l);
    check({8'h00, d}, 16'h00b5);
    check({15'h0000, busy}, 16'h0001);
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clock_in);
  endtask
  task automatic t_abort_data();
    int c, m;
    logic [7:0] d;
    logic [3:0] l;
    run_op('{FAA_CMD_ERASE, 1'b0, 8'h01, 10'h000}, 3, c, m);
    check(16'(c < 8), 16'h0001);
    // split data row
    // First of two passes writes the lower half of the row only.
    wmode <= 2'h1;
    run_op('{FAA_CMD_PROG, 1'b1, 8'h00, 10'h004}, -1, c, m);
    check(16'(m), 16'd31);
    check(16'(c), 16'd42);
    // Second pass writes the upper half and zeros over the lower half.
    wmode <= 2'h2;
    run_op('{FAA_CMD_PROG, 1'b1, 8'h00, 10'h004}, -1, c, m);
    check(16'(c), 16'd42);
    wmode <= 2'h0;
    fetch_byte(15'h0085, d, l);
    check({8'h00, d}, 16'h00a0);
    fetch_byte(15'h0094, d, l);
    check({8'h00, d}, 16'h00b1);
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    reset_n_in <= 1'b1;
    check({12'h000, cbanks}, 16'h0006);
    check({14'h0000, dbanks}, 16'h0002);
    t_erase_all();
    t_prog_fetch();
    t_background();
    t_abort_data();
    complete_run();
  end
endmodule
